/* File: test/esa_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module esa_host_model (
    input  wire logic mclk,          // system clock
    output logic      rd_orient_rep, // read of orientation report reg
    output logic      rd_sys_state   // read of system state reg
);
    // ----------------------------------------------------------------
    // register reads, one-cycle strobes launched at the falling edge
    // ----------------------------------------------------------------
    initial
    begin
        rd_orient_rep = 1'b0;
        rd_sys_state  = 1'b0;
    end

    task read_orient();
        @(negedge mclk);
        rd_orient_rep = 1'b1;
        @(negedge mclk);
        rd_orient_rep = 1'b0;
    endtask : read_orient

    task read_sys();
        @(negedge mclk);
        rd_sys_state = 1'b1;
        @(negedge mclk);
        rd_sys_state = 1'b0;
    endtask : read_sys
endmodule : esa_host_model
`default_nettype wire

/* File: test/tb_event_status_autosleep.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_event_status_autosleep;
    logic                  mclk, rst_n, sample_tick, fresh_orient, orient_changed;
    logic                  cfg_event, pstate_en, flex_mode, asleep, last_to_sleep;
    logic                  rd_orient_rep, rd_sys_state;
    logic [7:0]            limit_low, limit_high, summary;
    esa_pkg::esa_setting_t wake_set, sleep_set, applied;
    int                    err_total, total_checks;

    esa_host_model host (.mclk(mclk), .rd_orient_rep(rd_orient_rep), .rd_sys_state(rd_sys_state));

    esa_top dut (
        .mclk(mclk), .rst_n(rst_n), .sample_tick(sample_tick), .fresh_orient(fresh_orient),
        .orient_changed(orient_changed), .rd_orient_rep(rd_orient_rep),
        .rd_sys_state(rd_sys_state), .rd_summary(1'b0), .cfg_event(cfg_event),
        .limit_low(limit_low), .limit_high(limit_high), .pstate_en(pstate_en),
        .flex_mode(flex_mode), .wake_set(wake_set), .sleep_set(sleep_set),
        .summary(summary), .asleep(asleep), .last_to_sleep(last_to_sleep), .applied(applied)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask : chk

    task wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask : wait_n

    // an event pulse first, so the count always starts from zero
    task sleep_run(input int n);
        @(negedge mclk);
        cfg_event = 1'b1;
        @(negedge mclk);
        cfg_event = 1'b0;
        repeat (n)
        begin
            @(negedge mclk);
            sample_tick = 1'b1;
            @(negedge mclk);
            sample_tick = 1'b0;
        end
        wait_n(3);
    endtask : sleep_run

    task wake_up();
        cfg_event = 1'b1;
        wait_n(3);
        cfg_event = 1'b0;
    endtask : wake_up

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task orient_flag();
        fresh_orient = 1'b1;
        wait_n(3);
        chk("orient_no_change", 8'h00, {7'h0, summary[2]});
        orient_changed = 1'b1;
        wait_n(1);
        fresh_orient   = 1'b0;
        orient_changed = 1'b0;
        wait_n(2);
        chk("orient_set", 8'h04, summary & 8'hFB | 8'h04 & summary);
        host.read_orient();
        wait_n(1);
        chk("orient_cleared", 8'h00, {7'h0, summary[2]});
    endtask : orient_flag

    task auto_sleep();
        {limit_high, limit_low} = 16'h0002;
        host.read_sys();
        sleep_run(1);
        sleep_run(1);
        chk("restart_awake", 8'h00, {7'h0, asleep});
        sleep_run(2);
        chk("sleep_entered", 8'h01, {7'h0, asleep});
        chk("pstate_flag", 8'h02, summary);
        chk("dir_to_sleep", 8'h01, {7'h0, last_to_sleep});
        chk("sleep_set", {2'h0, sleep_set.power, sleep_set.rate}, {2'h0, applied.power, applied.rate});
        host.read_sys();
        wait_n(1);
        chk("flag_read_clr", 8'h00, {7'h0, summary[1]});
        wake_up();
        chk("woken", 8'h00, {7'h0, asleep});
        chk("wake_flag", 8'h01, {7'h0, summary[1]});
        chk("dir_to_wake", 8'h00, {7'h0, last_to_sleep});
        chk("wake_set", {2'h0, wake_set.power, wake_set.rate}, {2'h0, applied.power, applied.rate});
    endtask : auto_sleep

    task pair_limit();
        {limit_high, limit_low} = 16'h0100;
        sleep_run(255);
        chk("limit_255_awake", 8'h00, {7'h0, asleep});
        sleep_run(0);
        repeat (256)
        begin
            @(negedge mclk);
            sample_tick = 1'b1;
            @(negedge mclk);
            sample_tick = 1'b0;
        end
        wait_n(3);
        chk("limit_256_sleep", 8'h01, {7'h0, asleep});
        wake_up();
    endtask : pair_limit

    task gating();
        pstate_en = 1'b0;
        {limit_high, limit_low} = 16'h0002;
        host.read_sys();
        sleep_run(2);
        chk("en_off_sleeps", 8'h01, {7'h0, asleep});
        chk("en_off_noflag", 8'h00, {7'h0, summary[1]});
        wake_up();
        pstate_en = 1'b1;
        {limit_high, limit_low} = 16'h0000;
        sleep_run(4);
        chk("zero_limit_awake", 8'h00, {7'h0, asleep});
        chk("zero_limit_noflag", 8'h00, {7'h0, summary[1]});
    endtask : gating

    task flex_run();
        flex_mode = 1'b1;
        {limit_high, limit_low} = 16'h0002;
        sleep_run(2);
        chk("flex_sleep", {sleep_set.decim, sleep_set.idle}, {applied.decim, applied.idle});
        chk("flex_rate_hold", {4'h0, wake_set.rate}, {4'h0, applied.rate});
        wake_up();
        chk("flex_wake", {wake_set.decim, wake_set.idle}, {applied.decim, applied.idle});
    endtask : flex_run

    task give_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    initial
    begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    initial
    begin
        {rst_n, sample_tick, fresh_orient, orient_changed, cfg_event, flex_mode} = 6'h00;
        pstate_en  = 1'b1;
        limit_low  = 8'h00;
        limit_high = 8'h00;
        wake_set   = '{2'h1, 4'h5, 4'h3, 4'h2};
        sleep_set  = '{2'h2, 4'hA, 4'h7, 4'h6};
        err_total    = 0;
        total_checks = 0;
        wait_n(6);
        rst_n = 1'b1;
        wait_n(1);
        orient_flag();
        auto_sleep();
        pair_limit();
        gating();
        flex_run();
        give_verdict();
    end
endmodule : tb_event_status_autosleep
`default_nettype wire

/* File: verilog/esa_inact_cnt.sv */
`timescale 1ns/1ns
`default_nettype none
module esa_inact_cnt #(
    parameter int W = esa_pkg::ESA_LIMIT_W
) (
    input  wire logic         mclk,      // system clock
    input  wire logic         rst_n,     // async reset, active low
    input  wire logic         run,       // counting allowed
    input  wire logic         restart,   // configured event seen
    input  wire logic         tick,      // one output-sample period
    input  wire logic [W-1:0] limit,     // inactivity limit
    output logic              expired    // limit reached, one-cycle pulse
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic         exp_nxt;
    logic         exp_r;

    always_comb
    begin
        cnt_nxt = cnt_r;
        exp_nxt = 1'b0;
        if (!run || restart)
            cnt_nxt = '0;
        else if (tick)
        begin
            if (cnt_r + W'(1) >= limit)
            begin
                exp_nxt = 1'b1;
                cnt_nxt = '0;
            end
            else
                cnt_nxt = cnt_r + W'(1);
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= '0;
            exp_r <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign expired = exp_r;

    restart_clears_a: assert property (@(posedge mclk) disable iff (!rst_n)
        restart |=> (cnt_r == '0))
        else $error("counter not cleared by event");
endmodule : esa_inact_cnt
`default_nettype wire

/* File: verilog/esa_pkg.sv */
// Behaviour
// - set orientation-change flag, bit 2, on fresh orientation with orientation change
// - clear orientation-change flag when host reads orientation report register
// - set power-state-change flag, bit 1, on any wake/sleep transition
// - system state register reports direction of latest automatic transition
// - enter sleep after inactivity limit sample periods without configured event
// - on sleep apply sleep power setting and rate, or flexible decimation/idle
// - leave sleep at once when any configured event flag becomes active
// - on wake apply wake power setting and rate, or flexible decimation/idle
// - clear power-state-change flag when host reads system state register
// - auto wake/sleep and its flag work only while inactivity limit is nonzero
// - power-state-change flag works only while its event enable bit is set
package esa_pkg;

    // ----------------------------------------------------------------
    // register map and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] ESA_OFS_EVENT_SUMMARY = 8'h00;
    localparam int         ESA_BIT_ORIENT        = 2;
    localparam int         ESA_BIT_PSTATE        = 1;
    localparam logic [7:0] ESA_SUMMARY_RESET     = 8'h00;
    localparam int         ESA_LIMIT_W           = 16;
    localparam int         ESA_SETUP_W           = 8;

    typedef enum logic [1:0]
    {
        ESA_WAKE  = 2'h1,
        ESA_SLEEP = 2'h2
    } esa_mode_t;

    // settings applied to the sensing core in one mode
    typedef struct packed
    {
        logic [1:0] power;
        logic [3:0] rate;
        logic [3:0] decim;
        logic [3:0] idle;
    } esa_setting_t;

    localparam esa_setting_t ESA_SETTING_RESET = '{2'h0, 4'h0, 4'h0, 4'h0};

endpackage : esa_pkg

/* File: verilog/esa_setting_mux.sv */
`timescale 1ns/1ns
`default_nettype none
module esa_setting_mux (
    input  wire logic                  mclk,      // system clock
    input  wire logic                  rst_n,     // async reset, active low
    input  wire logic                  asleep,    // current mode is sleep
    input  wire logic                  flex,      // flexible performance mode
    input  wire esa_pkg::esa_setting_t wake_set,  // wake settings
    input  wire esa_pkg::esa_setting_t sleep_set, // sleep settings
    output esa_pkg::esa_setting_t      applied    // settings in force
);
    esa_pkg::esa_setting_t app_r;
    esa_pkg::esa_setting_t app_nxt;
    esa_pkg::esa_setting_t src;

    always_comb
    begin
        src     = asleep ? sleep_set : wake_set;
        app_nxt = src;
        // flexible mode keeps the fixed rate and swaps power and decimation/idle
        if (flex)
            app_nxt.rate = app_r.rate;
        else
        begin
            app_nxt.decim = app_r.decim;
            app_nxt.idle  = app_r.idle;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            app_r <= esa_pkg::ESA_SETTING_RESET;
        else
            app_r <= app_nxt;
    end

    assign applied = app_r;
endmodule : esa_setting_mux
`default_nettype wire

/* File: verilog/esa_top.sv */
`timescale 1ns/1ns
`default_nettype none
module esa_top #(
    parameter int LW = esa_pkg::ESA_LIMIT_W
) (
    input  wire logic                  mclk,            // system clock, 50 MHz
    input  wire logic                  rst_n,           // async reset, active low
    input  wire logic                  sample_tick,     // one pulse per output-sample period
    input  wire logic                  fresh_orient,    // fresh orientation bit
    input  wire logic                  orient_changed,  // orientation change detected
    input  wire logic                  rd_orient_rep,   // host read of orientation report reg
    input  wire logic                  rd_sys_state,    // host read of system state reg
    input  wire logic                  rd_summary,      // host read of event summary
    input  wire logic                  cfg_event,       // a configured event flag is active
    input  wire logic [7:0]            limit_low,       // inactivity limit low byte
    input  wire logic [7:0]            limit_high,      // inactivity limit high byte
    input  wire logic                  pstate_en,       // power state event enable
    input  wire logic                  flex_mode,       // flexible performance mode
    input  wire esa_pkg::esa_setting_t wake_set,        // wake power/rate/decim/idle
    input  wire esa_pkg::esa_setting_t sleep_set,       // sleep power/rate/decim/idle
    output logic [7:0]                 summary,         // event summary read data
    output logic                       asleep,          // system state: sleep
    output logic                       last_to_sleep,   // last transition was to sleep
    output esa_pkg::esa_setting_t      applied          // settings in force
);
    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    esa_pkg::esa_mode_t mode_r;
    esa_pkg::esa_mode_t mode_nxt;
    logic               orient_r;
    logic               orient_nxt;
    logic               pstate_r;
    logic               pstate_nxt;
    logic               dir_r;
    logic               dir_nxt;
    logic               asleep_r;
    logic               asleep_nxt;
    logic               event_d_r;
    logic [7:0]         summ_r;
    logic [7:0]         summ_nxt;
    logic [LW-1:0]      limit;
    logic               auto_on;
    logic               expired;
    logic               event_rise;
    logic               to_sleep;
    logic               to_wake;

    assign limit      = {limit_high, limit_low};
    assign auto_on    = (limit != '0);
    assign event_rise = cfg_event && !event_d_r;

    esa_inact_cnt #(
        .W       (LW)
    ) u_cnt (
        .mclk    (mclk),
        .rst_n   (rst_n),
        .run     (auto_on && (mode_r == esa_pkg::ESA_WAKE)),
        .restart (cfg_event),
        .tick    (sample_tick),
        .limit   (limit),
        .expired (expired)
    );

    // ----------------------------------------------------------------
    // mode machine
    // ----------------------------------------------------------------
    always_comb
    begin
        mode_nxt = mode_r;
        to_sleep = 1'b0;
        to_wake  = 1'b0;
        unique case (mode_r)
            esa_pkg::ESA_WAKE:
            begin
                if (auto_on && expired && !cfg_event)
                begin
                    mode_nxt = esa_pkg::ESA_SLEEP;
                    to_sleep = 1'b1;
                end
            end
            esa_pkg::ESA_SLEEP:
            begin
                if (cfg_event || !auto_on)
                begin
                    mode_nxt = esa_pkg::ESA_WAKE;
                    to_wake  = auto_on;
                end
            end
            default:
                mode_nxt = esa_pkg::ESA_WAKE;
        endcase
    end

    // ----------------------------------------------------------------
    // flags; a set in the same cycle as its clearing read wins
    // ----------------------------------------------------------------
    always_comb
    begin
        orient_nxt = orient_r;
        if (rd_orient_rep)
            orient_nxt = 1'b0;
        if (fresh_orient && orient_changed)
            orient_nxt = 1'b1;
        pstate_nxt = pstate_r;
        if (rd_sys_state)
            pstate_nxt = 1'b0;
        if ((to_sleep || to_wake) && pstate_en && auto_on)
            pstate_nxt = 1'b1;
        if (!auto_on || !pstate_en)
            pstate_nxt = 1'b0;
        dir_nxt = dir_r;
        if (to_sleep)
            dir_nxt = 1'b1;
        else if (to_wake)
            dir_nxt = 1'b0;
        summ_nxt = esa_pkg::ESA_SUMMARY_RESET;
        summ_nxt[esa_pkg::ESA_BIT_ORIENT] = orient_nxt;
        summ_nxt[esa_pkg::ESA_BIT_PSTATE] = pstate_nxt;
        // registered copy so the state output leaves straight from a flop
        asleep_nxt = (mode_nxt == esa_pkg::ESA_SLEEP);
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mode_r    <= esa_pkg::ESA_WAKE;
            orient_r  <= 1'b0;
            pstate_r  <= 1'b0;
            dir_r     <= 1'b0;
            asleep_r  <= 1'b0;
            event_d_r <= 1'b0;
            summ_r    <= esa_pkg::ESA_SUMMARY_RESET;
        end
        else
        begin
            mode_r    <= mode_nxt;
            orient_r  <= orient_nxt;
            pstate_r  <= pstate_nxt;
            dir_r     <= dir_nxt;
            asleep_r  <= asleep_nxt;
            event_d_r <= cfg_event;
            summ_r    <= summ_nxt;
        end
    end

    esa_setting_mux u_mux (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .asleep    (mode_r == esa_pkg::ESA_SLEEP),
        .flex      (flex_mode),
        .wake_set  (wake_set),
        .sleep_set (sleep_set),
        .applied   (applied)
    );

    assign summary       = summ_r;
    assign asleep        = asleep_r;
    assign last_to_sleep = dir_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    orient_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (fresh_orient && orient_changed) |=> orient_r)
        else $error("orientation flag not set");
    orient_clr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (rd_orient_rep && !(fresh_orient && orient_changed)) |=> !orient_r)
        else $error("orientation flag not cleared");
    pstate_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ((to_sleep || to_wake) && pstate_en) |=> pstate_r)
        else $error("power state flag not set");
    dir_track_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (mode_r == esa_pkg::ESA_WAKE) ##1 (mode_r == esa_pkg::ESA_SLEEP)
        |-> last_to_sleep)
        else $error("direction not reported");
    sleep_entry_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (expired && auto_on && !cfg_event && mode_r == esa_pkg::ESA_WAKE)
        |=> asleep)
        else $error("sleep not entered");
    wake_exit_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (asleep && cfg_event) |=> !asleep)
        else $error("wake not taken");
    sleep_apply_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (asleep && $stable(sleep_set) && !flex_mode) ##1 (asleep && !flex_mode)
        |-> applied.power == sleep_set.power)
        else $error("sleep setting not applied");
    wake_apply_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (!asleep && $stable(wake_set)) ##1 !asleep
        |-> applied.power == wake_set.power)
        else $error("wake setting not applied");
    pstate_clr_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (rd_sys_state && !to_sleep && !to_wake) |=> !pstate_r)
        else $error("power state flag not cleared");
    zero_limit_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (limit == '0) |=> (!asleep && !pstate_r))
        else $error("auto mode active at zero limit");
    en_gate_a: assert property (@(posedge mclk) disable iff (!rst_n)
        !pstate_en |=> !pstate_r)
        else $error("power state flag without enable");

    sleep_cov_c: cover property (@(posedge mclk) disable iff (!rst_n) to_sleep);
    wake_cov_c: cover property (@(posedge mclk) disable iff (!rst_n) to_wake);
    orient_cov_c: cover property (@(posedge mclk) disable iff (!rst_n)
        orient_r ##1 !orient_r);
    both_cov_c: cover property (@(posedge mclk) disable iff (!rst_n)
        orient_r && pstate_r);
    rise_cov_c: cover property (@(posedge mclk) disable iff (!rst_n)
        asleep && event_rise);
endmodule : esa_top
`default_nettype wire
